// ---- core/ipe_mask.sv ----
// Module: per-source enable gating with global gate
`timescale 1ns/1ps
module ipe_mask
  import ipe_pkg::*;
#(
  parameter int N = ipe_pkg::IPE_NSRC
)
(
  input  wire logic [N-1:0] req_i,
  input  wire logic [N-1:0] en_i,
  input  wire logic         gate_i,
  output logic      [N-1:0] act_o
);
  // Global gate overrides every individual mask
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_m
      assign act_o[g] = gate_i & en_i[g] & req_i[g]; // [R17]
    end
  endgenerate
endmodule

// ---- core/ipe_pick.sv ----
// Module: lowest-index pick among pending requests
`timescale 1ns/1ps
module ipe_pick
#(
  parameter int N = 15,
  parameter int W = 4
)
(
  input  wire logic [N-1:0] req_i,
  output logic              any_o,
  output logic      [W-1:0] idx_o
);
  // Lowest index wins, as the fixed polling order within a level
  always_comb
  begin
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req_i[i])
      begin
        idx_o = W'(i);
      end
    end
  end
  assign any_o = |req_i;
endmodule

// ---- core/ipe_pkg.sv ----
// Package: register map, field positions and reset values of the irq block
package ipe_pkg;
  // Register addresses on the special function register port
  localparam logic [7:0] IPE_ADDR_PRIO  = 8'hb8;
  localparam logic [7:0] IPE_ADDR_EMASK = 8'he6;
  localparam logic [7:0] IPE_ADDR_BMASK = 8'ha8;
  // Reset values
  localparam logic [7:0] IPE_RST_PRIO   = 8'h80;
  localparam logic [7:0] IPE_RST_EMASK  = 8'h00;
  localparam logic [7:0] IPE_RST_BMASK  = 8'h00;
  // Field positions
  localparam int IPE_PRIO_RSVD_BIT = 7;
  localparam int IPE_GATE_BIT      = 7;
  // Source counts
  localparam int IPE_NBASIC = 7;
  localparam int IPE_NEXT   = 8;
  localparam int IPE_NSRC   = 15;
  // Service level of the CPU
  typedef enum logic [1:0]
  {
    IPE_LVL_IDLE = 2'b00,
    IPE_LVL_LOW  = 2'b01,
    IPE_LVL_HIGH = 2'b10,
    IPE_LVL_BOTH = 2'b11
  } ipe_lvl_t;
endpackage

// ---- core/ipe_top.sv ----
// Module: interrupt priority and extended enable controller
// Operation
// R1: Reserved priority bit written as reset value
// R2: Bit 6 sets SPI priority
// R3: Bit 5 sets timer 2 priority
// R4: Bit 4 sets UART priority
// R5: Bit 3 sets timer 1 priority
// R6: Bit 2 sets external interrupt 1 priority
// R7: Bit 1 sets timer 0 priority
// R8: Bit 0 sets external interrupt 0 priority
// R9: Bit 7 enables timer 3, either flag
// R10: Bit 6 enables comparator 1, either edge
// R11: Bit 5 enables comparator 0, either edge
// R12: Bit 4 enables counter array requests
// R13: Bit 3 enables ADC done request
// R14: Bit 2 enables ADC window request
// R15: Bit 1 enables port match requests
// R16: Bit 0 enables SMBus requests
// R17: Global gate overrides all individual masks
// R18: High preempts low; equal waits for return
`timescale 1ns/1ps
module ipe_top
  import ipe_pkg::*;
(
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic [7:0]                  sfr_addr_i,
  input  wire logic [7:0]                  sfr_wdata_i,
  input  wire logic                        sfr_wr_i,
  input  wire logic                        sfr_rd_i,
  output logic      [7:0]                  sfr_rdata_o,
  input  wire logic [ipe_pkg::IPE_NBASIC-1:0] basic_req_i,
  input  wire logic [1:0]                  timer_three_ovf_i,
  input  wire logic [1:0]                  comparator_one_flags_i,
  input  wire logic [1:0]                  comparator_zero_flags_i,
  input  wire logic                        counter_array_req_i,
  input  wire logic                        adc_done_flag_i,
  input  wire logic                        adc_window_match_flag_i,
  input  wire logic                        port_match_req_i,
  input  wire logic                        smbus_req_i,
  input  wire logic [ipe_pkg::IPE_NEXT-1:0] ext_prio_i,
  input  wire logic                        irq_ack_i,
  input  wire logic                        irq_ret_i,
  output logic                             irq_req_o,
  output logic                             irq_high_o,
  output logic      [3:0]                  irq_idx_o,
  output logic      [1:0]                  irq_level_o
);
  import ipe_pkg::*;

  // Architectural registers
  logic [7:0]      basic_priority_reg_r;
  logic [7:0]      extended_mask_reg_r;
  logic [7:0]      basic_mask_reg_r;
  logic [7:0]      rdata_r;
  ipe_lvl_t        lvl_r;
  ipe_lvl_t        lvl_nxt;
  logic            req_r;
  logic            high_r;
  logic [3:0]      idx_r;

  // Address decode
  wire wr_prio  = sfr_wr_i & (sfr_addr_i == IPE_ADDR_PRIO);
  wire wr_emask = sfr_wr_i & (sfr_addr_i == IPE_ADDR_EMASK);
  wire wr_bmask = sfr_wr_i & (sfr_addr_i == IPE_ADDR_BMASK);

  // Read mux; unmapped addresses read zero
  wire [7:0] rd_mux =
    (sfr_addr_i == IPE_ADDR_PRIO)  ? basic_priority_reg_r :
    (sfr_addr_i == IPE_ADDR_EMASK) ? extended_mask_reg_r  :
    (sfr_addr_i == IPE_ADDR_BMASK) ? basic_mask_reg_r     : 8'h00;

  // Register writes; the reserved bit holds its reset value whatever is
  // written, so a careless write cannot change it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      basic_priority_reg_r <= IPE_RST_PRIO;
      extended_mask_reg_r  <= IPE_RST_EMASK;
      basic_mask_reg_r     <= IPE_RST_BMASK;
      rdata_r              <= 8'h00;
    end
    else
    begin
      if (wr_prio)
        basic_priority_reg_r <= {IPE_RST_PRIO[IPE_PRIO_RSVD_BIT],
                                 sfr_wdata_i[6:0]}; // [R1]
      if (wr_emask)
        extended_mask_reg_r <= sfr_wdata_i;
      if (wr_bmask)
        basic_mask_reg_r <= sfr_wdata_i;
      if (sfr_rd_i)
        rdata_r <= rd_mux;
    end
  end

  // Field views of the priority register
  wire serial_periph_prio = basic_priority_reg_r[6]; // [R2]
  wire timer_two_prio     = basic_priority_reg_r[5]; // [R3]
  wire uart_prio          = basic_priority_reg_r[4]; // [R4]
  wire timer_one_prio     = basic_priority_reg_r[3]; // [R5]
  wire ext_int_one_prio   = basic_priority_reg_r[2]; // [R6]
  wire timer_zero_prio    = basic_priority_reg_r[1]; // [R7]
  wire ext_int_zero_prio  = basic_priority_reg_r[0]; // [R8]

  // Field views of the extended mask register and the basic mask gate bit
  wire timer_three_enable    = extended_mask_reg_r[7];
  wire comparator_one_enable = extended_mask_reg_r[6];
  wire comparator_zero_enable = extended_mask_reg_r[5];
  wire counter_array_enable  = extended_mask_reg_r[4];
  wire adc_done_enable       = extended_mask_reg_r[3];
  wire adc_window_enable     = extended_mask_reg_r[2];
  wire port_match_enable     = extended_mask_reg_r[1];
  wire smbus_enable          = extended_mask_reg_r[0];
  wire global_irq_gate       = basic_mask_reg_r[IPE_GATE_BIT];

  // Extended source requests; timer 3 and each comparator merge two flags onto one request line
  wire [IPE_NEXT-1:0] ext_req;
  assign ext_req[7] = |timer_three_ovf_i;       // [R9]
  assign ext_req[6] = |comparator_one_flags_i;  // [R10]
  assign ext_req[5] = |comparator_zero_flags_i; // [R11]
  assign ext_req[4] = counter_array_req_i;      // [R12]
  assign ext_req[3] = adc_done_flag_i;          // [R13]
  assign ext_req[2] = adc_window_match_flag_i;  // [R14]
  assign ext_req[1] = port_match_req_i;         // [R15]
  assign ext_req[0] = smbus_req_i;              // [R16]

  // Source vector: basic sources 0..6 from ext0 upward, extended 7..14
  // ordered from SMBus up to timer 3
  wire [IPE_NSRC-1:0] all_req;
  wire [IPE_NSRC-1:0] all_en;
  wire [IPE_NSRC-1:0] all_prio;
  wire [IPE_NSRC-1:0] act;
  assign all_req  = {ext_req, basic_req_i};
  assign all_en   = {timer_three_enable, comparator_one_enable,
                     comparator_zero_enable, counter_array_enable,
                     adc_done_enable, adc_window_enable,
                     port_match_enable, smbus_enable,
                     basic_mask_reg_r[6:0]}; // [R9] [R16]
  assign all_prio = {ext_prio_i, serial_periph_prio, timer_two_prio,
                     uart_prio, timer_one_prio, ext_int_one_prio,
                     timer_zero_prio, ext_int_zero_prio};

  ipe_mask #(.N(IPE_NSRC)) u_mask
  (
    .req_i  (all_req),
    .en_i   (all_en),
    .gate_i (global_irq_gate),
    .act_o  (act)
  );

  // Split active requests by level
  wire [IPE_NSRC-1:0] act_hi = act & all_prio;
  wire [IPE_NSRC-1:0] act_lo = act & ~all_prio;
  wire       any_hi;
  wire       any_lo;
  wire [3:0] idx_hi;
  wire [3:0] idx_lo;

  ipe_pick #(.N(IPE_NSRC), .W(4)) u_pick_hi
  (
    .req_i (act_hi),
    .any_o (any_hi),
    .idx_o (idx_hi)
  );

  ipe_pick #(.N(IPE_NSRC), .W(4)) u_pick_lo
  (
    .req_i (act_lo),
    .any_o (any_lo),
    .idx_o (idx_lo)
  );

  // Eligibility: high only preempts when no high routine runs; low only
  // when the CPU is idle
  wire in_high  = lvl_r[1];
  wire in_any   = |lvl_r;
  wire elig_hi  = any_hi & ~in_high;                  // [R18]
  wire elig_lo  = any_lo & ~in_any;                   // [R18]
  wire win      = elig_hi | elig_lo;
  wire win_high = elig_hi;
  wire [3:0] win_idx = elig_hi ? idx_hi : idx_lo;

  // Level tracking: ack enters the granted level, return leaves the
  // innermost; a high routine nested over a low one returns to low
  always_comb
  begin
    lvl_nxt = lvl_r;
    if (irq_ret_i)
    begin
      unique case (lvl_r)
        IPE_LVL_IDLE: lvl_nxt = IPE_LVL_IDLE;
        IPE_LVL_LOW:  lvl_nxt = IPE_LVL_IDLE;
        IPE_LVL_HIGH: lvl_nxt = IPE_LVL_IDLE;
        IPE_LVL_BOTH: lvl_nxt = IPE_LVL_LOW;
      endcase
    end
    else if (irq_ack_i && req_r)
    begin
      lvl_nxt = high_r ? ipe_lvl_t'({1'b1, lvl_r[0]})
                       : IPE_LVL_LOW; // [R18]
    end
  end

  // Request outputs registered; held low while an ack is being taken
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lvl_r  <= IPE_LVL_IDLE;
      req_r  <= 1'b0;
      high_r <= 1'b0;
      idx_r  <= 4'h0;
    end
    else
    begin
      lvl_r  <= lvl_nxt;
      req_r  <= win & ~irq_ack_i;
      high_r <= win_high;
      idx_r  <= win_idx;
    end
  end

  assign irq_req_o   = req_r;
  assign irq_high_o  = high_r;
  assign irq_idx_o   = idx_r;
  assign irq_level_o = lvl_r;
  assign sfr_rdata_o = rdata_r;

  // Checks
  property p_rsvd;
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |-> basic_priority_reg_r[IPE_PRIO_RSVD_BIT];
  endproperty
  a_rsvd: assert property (p_rsvd) // [R1]
    else $error("reserved priority bit changed");

  property p_gate;
    @(posedge clk_i) disable iff (rst_i)
    !global_irq_gate ##1 !global_irq_gate |-> !req_r;
  endproperty
  a_gate: assert property (p_gate) // [R17]
    else $error("request raised with global gate off");

  property p_no_low_nest;
    @(posedge clk_i) disable iff (rst_i)
    (lvl_r != IPE_LVL_IDLE) && $past(lvl_r != IPE_LVL_IDLE) && req_r
      |-> high_r;
  endproperty
  a_no_low_nest: assert property (p_no_low_nest) // [R18]
    else $error("low request during active routine");

  property p_no_high_nest;
    @(posedge clk_i) disable iff (rst_i)
    lvl_r[1] && $past(lvl_r[1]) |-> !req_r;
  endproperty
  a_no_high_nest: assert property (p_no_high_nest) // [R18]
    else $error("request during high routine");

  property p_t3_mask;
    @(posedge clk_i) disable iff (rst_i)
    req_r && (idx_r == 4'he) |-> $past(timer_three_enable);
  endproperty
  a_t3_mask: assert property (p_t3_mask) // [R9]
    else $error("timer 3 request while masked");

  property p_smb_mask;
    @(posedge clk_i) disable iff (rst_i)
    req_r && (idx_r == 4'h7) |-> $past(smbus_enable);
  endproperty
  a_smb_mask: assert property (p_smb_mask) // [R16]
    else $error("smbus request while masked");

  property p_spi_prio;
    @(posedge clk_i) disable iff (rst_i)
    req_r && (idx_r == 4'h6) |-> high_r == $past(serial_periph_prio);
  endproperty
  a_spi_prio: assert property (p_spi_prio) // [R2]
    else $error("spi level mismatch");

  property p_ext0_prio;
    @(posedge clk_i) disable iff (rst_i)
    req_r && (idx_r == 4'h0) |-> high_r == $past(ext_int_zero_prio);
  endproperty
  a_ext0_prio: assert property (p_ext0_prio) // [R8]
    else $error("ext int 0 level mismatch");
endmodule

// ---- tb/ipe_cpu_model.sv ----
// CPU-side model: takes offered requests after a delay, returns on command
`timescale 1ns/1ps
module ipe_cpu_model
#(
  parameter int LAT = 2
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic irq_req_i,
  input  wire logic take_i,
  input  wire logic leave_i,
  output logic      irq_ack_o,
  output logic      irq_ret_o
);
  int wait_r;

  // Ack is a single pulse; no re-ack while the taken request is dropping
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_ack_o <= 1'b0;
      irq_ret_o <= 1'b0;
      wait_r    <= 0;
    end
    else
    begin
      irq_ack_o <= 1'b0;
      irq_ret_o <= leave_i;
      if (irq_req_i && take_i && !irq_ack_o)
      begin
        if (wait_r >= LAT)
        begin
          irq_ack_o <= 1'b1;
          wait_r    <= 0;
        end
        else
          wait_r <= wait_r + 1;
      end
      else
        wait_r <= 0;
    end
  end
endmodule

// ---- tb/irq_priority_and_ext_enable_tb.sv ----
// Testbench: register access, masking and priority of the irq block
`timescale 1ns/1ps
module irq_priority_and_ext_enable_tb;
  import ipe_pkg::*;
  logic       clk_i;
  logic       rst_i;
  logic [7:0] sfr_addr_i;
  logic [7:0] sfr_wdata_i;
  logic       sfr_wr_i;
  logic       sfr_rd_i;
  logic [7:0] sfr_rdata_o;
  logic [6:0] basic_req_i;
  logic [1:0] t3_i;
  logic [1:0] cp1_i;
  logic [1:0] cp0_i;
  logic [4:0] misc_i;   // Sources 7..11, one bit each
  logic [7:0] ext_prio_i;
  logic       irq_ack_i;
  logic       irq_ret_i;
  logic       irq_req_o;
  logic       irq_high_o;
  logic [3:0] irq_idx_o;
  logic [1:0] irq_level_o;
  logic       take;
  logic       leave;
  int         miscompares;
  int         cmp_count;

  ipe_top DUT (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o), .basic_req_i(basic_req_i),
    .timer_three_ovf_i(t3_i), .comparator_one_flags_i(cp1_i),
    .comparator_zero_flags_i(cp0_i), .counter_array_req_i(misc_i[4]),
    .adc_done_flag_i(misc_i[3]), .adc_window_match_flag_i(misc_i[2]),
    .port_match_req_i(misc_i[1]), .smbus_req_i(misc_i[0]),
    .ext_prio_i(ext_prio_i), .irq_ack_i(irq_ack_i), .irq_ret_i(irq_ret_i),
    .irq_req_o(irq_req_o), .irq_high_o(irq_high_o),
    .irq_idx_o(irq_idx_o), .irq_level_o(irq_level_o));

  // Slow partner so the request is visible before it is taken
  ipe_cpu_model #(.LAT(2)) cpu (.clk_i(clk_i), .rst_i(rst_i),
    .irq_req_i(irq_req_o), .take_i(take), .leave_i(leave),
    .irq_ack_o(irq_ack_i), .irq_ret_o(irq_ret_i));

  // Free-running 250 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i  = a;
    sfr_wdata_i = d;
    sfr_wr_i    = 1'b1;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
  endtask

  // Read data is registered, so sample a full cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_rd_i   = 1'b1;
    @(negedge clk_i);
    sfr_rd_i = 1'b0;
    @(negedge clk_i);
    chk("rdata", e, sfr_rdata_o);
  endtask

  task automatic settle();
    repeat (8) @(negedge clk_i);
  endtask

  task automatic irq_chk(input logic r, input logic [3:0] ix,
                         input logic h);
    chk("irq_req", {7'h00, r}, {7'h00, irq_req_o});
    chk("irq_idx", {4'h0, ix}, {4'h0, irq_idx_o});
    chk("irq_high", {7'h00, h}, {7'h00, irq_high_o});
  endtask

  // One source pending at a time; index 15 clears them all
  task automatic set_src(input int i, input int alt);
    basic_req_i = '0;
    t3_i        = '0;
    cp1_i       = '0;
    cp0_i       = '0;
    misc_i      = '0;
    if (i < 7)
      basic_req_i[i] = 1'b1;
    else if (i < 12)
      misc_i[i-7] = 1'b1;
    else if (i == 12)
      cp0_i[alt] = 1'b1;
    else if (i == 13)
      cp1_i[alt] = 1'b1;
    else if (i == 14)
      t3_i[alt] = 1'b1;
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {sfr_addr_i, sfr_wdata_i, sfr_wr_i, sfr_rd_i, ext_prio_i} = '0;
    {take, leave, miscompares, cmp_count} = '0;
    set_src(15, 0);
    rst_i = 1'b1;
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    rd_chk(IPE_ADDR_PRIO, IPE_RST_PRIO);
    rd_chk(IPE_ADDR_EMASK, IPE_RST_EMASK);
    rd_chk(IPE_ADDR_BMASK, IPE_RST_BMASK);
    rd_chk(8'h00, 8'h00);
    wr(IPE_ADDR_EMASK, 8'ha5);
    rd_chk(IPE_ADDR_EMASK, 8'ha5);
    $display("test registers done");
    wr(IPE_ADDR_BMASK, 8'hff);
    for (int i = 0; i < 7; i++)
      for (int p = 0; p < 2; p++)
      begin
        wr(IPE_ADDR_PRIO, 8'h80 | (8'(p) << i));
        set_src(i, 0);
        settle();
        irq_chk(1'b1, 4'(i), p[0]);
      end
    wr(IPE_ADDR_BMASK, 8'h7f);
    settle();
    chk("irq_req gated", 8'h00, {7'h00, irq_req_o});
    wr(IPE_ADDR_BMASK, 8'hff);
    $display("test basic priority done");
    for (int i = 7; i < 15; i++)
      for (int a = 0; a < 2; a++)
      begin
        ext_prio_i = {8{a[0]}};
        set_src(i, a);
        wr(IPE_ADDR_EMASK, ~(8'h01 << (i - 7)));
        settle();
        chk("irq_req masked", 8'h00, {7'h00, irq_req_o});
        wr(IPE_ADDR_EMASK, 8'h01 << (i - 7));
        settle();
        irq_chk(1'b1, 4'(i), a[0]);
      end
    $display("test extended enable done");
    set_src(15, 0);
    ext_prio_i = 8'h00;
    wr(IPE_ADDR_PRIO, 8'h81);
    basic_req_i = 7'h02;
    take = 1'b1;
    settle();
    chk("level low", 8'h01, {6'h00, irq_level_o});
    chk("irq_req low busy", 8'h00, {7'h00, irq_req_o});
    take = 1'b0;
    basic_req_i = 7'h03;
    settle();
    irq_chk(1'b1, 4'h0, 1'b1);
    take = 1'b1;
    settle();
    chk("level both", 8'h03, {6'h00, irq_level_o});
    basic_req_i = 7'h02;
    leave = 1'b1;
    @(negedge clk_i);
    leave = 1'b0;
    settle();
    chk("level after ret", 8'h01, {6'h00, irq_level_o});
    chk("irq_req held", 8'h00, {7'h00, irq_req_o});
    take = 1'b0;
    leave = 1'b1;
    @(negedge clk_i);
    leave = 1'b0;
    settle();
    irq_chk(1'b1, 4'h1, 1'b0);
    $display("test preemption done");
    complete_run();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #80000;
    miscompares++;
    complete_run();
  end
endmodule
